// File: verilog/adcr_dataflow_clock_routing.v
// data-flow switch and clock routing of the audio transceiver
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "adcr_regs.vh"
module adcr_dataflow_clock_routing #(
  parameter W     = 24,
  parameter DEPTH = 2,
  parameter AW    = 1
) (
  input  wire         clk_sys,
  input  wire         srst,
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire [7:0]   paddr,
  input  wire [31:0]  pwdata,
  output reg  [31:0]  prdata,
  output wire         pready,
  output wire         pslverr,
  input  wire         aes_rx_valid,
  output wire         aes_rx_ready,
  input  wire [W-1:0] aes_rx_data,
  input  wire         ser_in_valid,
  output wire         ser_in_ready,
  input  wire [W-1:0] ser_in_data,
  input  wire         src_out_valid,
  output wire         src_out_ready,
  input  wire [W-1:0] src_out_data,
  output wire         src_in_valid,
  input  wire         src_in_ready,
  output wire [W-1:0] src_in_data,
  output wire         ser_out_valid,
  input  wire         ser_out_ready,
  output wire [W-1:0] ser_out_data,
  output wire         aes_tx_valid,
  input  wire         aes_tx_ready,
  output wire [W-1:0] aes_tx_data,
  input  wire         receive_pos_input,
  input  wire         tx_enc_pos,
  input  wire         tx_enc_neg,
  output reg          transmit_pos_output,
  output reg          transmit_neg_output,
  input  wire         recovered_master_clock,
  input  wire         external_master_clock,
  input  wire         recovered_clock_pin_i,
  output reg          recovered_clock_pin_o,
  output reg          recovered_clock_pin_oe,
  output reg          pll_ref_aes,
  output reg          pll_bypass,
  output reg          in_domain_clk,
  output reg          out_domain_clk,
  output reg          in_clk_falling,
  output reg          out_clk_falling,
  output reg  [3:0]   flow_id
);
  // ============================================================
  // configuration registers
  reg  [7:0] flow_ctrl;
  reg  [3:0] clk_ctrl;
  wire       converter_disable;
  wire [1:0] serial_out_source_select;
  wire [1:0] transmit_source_select;
  wire       src_in_aes;
  wire       transmit_off;
  wire       biphase_bypass_switch;
  wire [1:0] receive_clock_select;
  wire       out_clk_recovered;
  wire       passthrough;
  assign converter_disable        = flow_ctrl[`ADCR_CONVERTER_DISABLE];
  assign serial_out_source_select =
    flow_ctrl[`ADCR_SER_OUT_SEL_LO+1:`ADCR_SER_OUT_SEL_LO];
  assign transmit_source_select   =
    flow_ctrl[`ADCR_TX_SRC_SEL_LO+1:`ADCR_TX_SRC_SEL_LO];
  assign src_in_aes               = flow_ctrl[`ADCR_SRC_IN_AES];
  assign transmit_off             = flow_ctrl[`ADCR_TRANSMIT_OFF];
  assign biphase_bypass_switch    = flow_ctrl[`ADCR_BYPASS_SWITCH];
  assign receive_clock_select     =
    clk_ctrl[`ADCR_RX_CLK_SEL_LO+1:`ADCR_RX_CLK_SEL_LO];
  assign out_clk_recovered        = clk_ctrl[`ADCR_OUT_CLK_RECOVERED];
  assign passthrough              = clk_ctrl[`ADCR_PASSTHROUGH];
  // ============================================================
  // apb slave: zero wait states, error on unmapped offsets
  wire       hit_flow;
  wire       hit_clk;
  wire       hit_stat;
  wire       mapped;
  wire       wr_en;
  reg        cfg_invalid;
  wire [31:0] status_word;
  assign hit_flow = (paddr == `ADCR_FLOW_CTRL_OFS);
  assign hit_clk  = (paddr == `ADCR_CLK_CTRL_OFS);
  assign hit_stat = (paddr == `ADCR_STATUS_OFS);
  assign mapped   = hit_flow | hit_clk | hit_stat;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;
  assign wr_en    = psel & penable & pwrite;
  assign status_word = {15'h0000, `ADCR_PLL_MULT, 1'b0, out_clk_falling,
                        in_clk_falling, cfg_invalid, flow_id};
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      flow_ctrl <= `ADCR_FLOW_CTRL_RST;
      clk_ctrl  <= `ADCR_CLK_CTRL_RST;
      prdata    <= 32'h00000000;
    end
    else
    begin
      if (wr_en & hit_flow)
        flow_ctrl <= pwdata[7:0];
      if (wr_en & hit_clk)
        clk_ctrl <= pwdata[3:0];
      // read data is captured in the setup cycle so it comes from a flop
      if (psel & ~penable)
      begin
        if (hit_flow)
          prdata <= {24'h000000, flow_ctrl};
        else if (hit_clk)
          prdata <= {28'h0000000, clk_ctrl};
        else if (hit_stat)
          prdata <= status_word;
        else
          prdata <= 32'h00000000;
      end
    end
  end
  // ============================================================
  // flow identification
  reg [3:0] next_flow_id;
  always @*
  begin
    next_flow_id = 4'h0;
    if (~converter_disable &&
        serial_out_source_select == `ADCR_SEL_CONVERTER &&
        transmit_source_select == `ADCR_SEL_CONVERTER)
    begin
      if (src_in_aes)
        next_flow_id = 4'h3;
      else if (receive_clock_select == `ADCR_RXC_PLL_WORD)
        next_flow_id = 4'h1;
      else if (receive_clock_select == `ADCR_RXC_PIN_IN)
        next_flow_id = 4'h2;
      else if (receive_clock_select == `ADCR_RXC_PLL_AES)
        next_flow_id = 4'h4;
      else if (out_clk_recovered)
        next_flow_id = 4'h5;
    end
    else if (~converter_disable && src_in_aes &&
             serial_out_source_select == `ADCR_SEL_CONVERTER &&
             transmit_source_select == `ADCR_SEL_SERIAL_IN)
      next_flow_id = 4'h6;
    else if (converter_disable &&
             serial_out_source_select == `ADCR_SEL_AES_RX &&
             transmit_source_select == `ADCR_SEL_SERIAL_IN)
      next_flow_id = 4'h7;
    else if (~converter_disable &&
             serial_out_source_select == `ADCR_SEL_AES_RX &&
             transmit_source_select == `ADCR_SEL_NONE &&
             receive_clock_select == `ADCR_RXC_PLL_AES)
      next_flow_id = 4'h8;
    else if (~converter_disable &&
             serial_out_source_select == `ADCR_SEL_SERIAL_IN &&
             transmit_source_select == `ADCR_SEL_SERIAL_IN &&
             receive_clock_select == `ADCR_RXC_PLL_WORD)
      next_flow_id = 4'h9;
  end
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      flow_id     <= 4'h0;
      cfg_invalid <= 1'b1;
    end
    else
    begin
      flow_id     <= next_flow_id;
      cfg_invalid <= (next_flow_id == 4'h0);
    end
  end
  // ============================================================
  // data switch: sources aes rx (bit 0), serial in (1), converter (2)
  function [2:0] onehot_src;
    input [1:0] code;
    begin
      case (code)
        `ADCR_SEL_CONVERTER: onehot_src = 3'b100;
        `ADCR_SEL_SERIAL_IN: onehot_src = 3'b010;
        `ADCR_SEL_AES_RX:    onehot_src = 3'b001;
        default:             onehot_src = 3'b000;
      endcase
    end
  endfunction
  wire [2:0] use_so;
  wire [2:0] use_tx;
  wire [2:0] use_si;
  wire [2:0] used;
  wire [2:0] src_vld;
  wire [2:0] src_rdy;
  wire [2:0] fire;
  wire       conv_needed;
  wire       so_rdy;
  wire       tx_rdy;
  wire       si_rdy;
  // a disabled converter can feed nobody, so its selection is dropped
  assign use_so = onehot_src(serial_out_source_select) &
                  {~converter_disable, 2'b11};
  assign use_tx = onehot_src(transmit_source_select) &
                  {~converter_disable, 2'b11};
  assign conv_needed = use_so[2] | use_tx[2];
  assign use_si = conv_needed ? (src_in_aes ? 3'b001 : 3'b010) : 3'b000;
  assign used   = use_so | use_tx | use_si;
  assign src_vld = {src_out_valid, ser_in_valid, aes_rx_valid};
  // a source feeding two sinks moves only when both can take the word;
  // an unrouted source is held rather than silently drained
  assign src_rdy = used & (~use_so | {3{so_rdy}}) &
                   (~use_tx | {3{tx_rdy}}) & (~use_si | {3{si_rdy}});
  assign fire = src_vld & src_rdy;
  assign aes_rx_ready  = src_rdy[0];
  assign ser_in_ready  = src_rdy[1];
  assign src_out_ready = src_rdy[2];
  function [W-1:0] pick;
    input [2:0]   sel;
    input [W-1:0] d_aes;
    input [W-1:0] d_ser;
    input [W-1:0] d_conv;
    begin
      if (sel[0])
        pick = d_aes;
      else if (sel[1])
        pick = d_ser;
      else
        pick = d_conv;
    end
  endfunction
  adcr_buf2 #(.W(W), .DEPTH(DEPTH), .AW(AW)) u_buf_ser_out (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .in_valid  (|(use_so & fire)),
    .in_ready  (so_rdy),
    .in_data   (pick(use_so, aes_rx_data, ser_in_data, src_out_data)),
    .out_valid (ser_out_valid),
    .out_ready (ser_out_ready),
    .out_data  (ser_out_data)
  );
  adcr_buf2 #(.W(W), .DEPTH(DEPTH), .AW(AW)) u_buf_aes_tx (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .in_valid  (|(use_tx & fire)),
    .in_ready  (tx_rdy),
    .in_data   (pick(use_tx, aes_rx_data, ser_in_data, src_out_data)),
    .out_valid (aes_tx_valid),
    .out_ready (aes_tx_ready),
    .out_data  (aes_tx_data)
  );
  adcr_buf2 #(.W(W), .DEPTH(DEPTH), .AW(AW)) u_buf_src_in (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .in_valid  (|(use_si & fire)),
    .in_ready  (si_rdy),
    .in_data   (pick(use_si, aes_rx_data, ser_in_data, src_out_data)),
    .out_valid (src_in_valid),
    .out_ready (src_in_ready),
    .out_data  (src_in_data)
  );
  // ============================================================
  // pin synchronisers: receive input, pll clock, master clock, clock pin
  reg [3:0] pin_s1;
  reg [3:0] pin_s2;
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
    end
    else
    begin
      pin_s1 <= {recovered_clock_pin_i, external_master_clock,
                 recovered_master_clock, receive_pos_input};
      pin_s2 <= pin_s1;
    end
  end
  // ============================================================
  // transmit drivers
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      transmit_pos_output <= 1'b0;
      transmit_neg_output <= 1'b0;
    end
    else if (transmit_off)
    begin
      transmit_pos_output <= 1'b0;
      transmit_neg_output <= 1'b0;
    end
    else if (biphase_bypass_switch)
    begin
      // bypass ignores the selected flow, so it works in all of them
      transmit_pos_output <= pin_s2[0];
      transmit_neg_output <= ~pin_s2[0];
    end
    else
    begin
      transmit_pos_output <= tx_enc_pos;
      transmit_neg_output <= tx_enc_neg;
    end
  end
  // ============================================================
  // clock routing
  reg [1:0] in_src;
  reg [1:0] out_src;
  always @*
  begin
    case (receive_clock_select)
      `ADCR_RXC_PLL_WORD: in_src = `ADCR_CLK_PLL;
      `ADCR_RXC_PLL_AES:  in_src = `ADCR_CLK_PLL;
      // passthrough owns the pin, so the input side keeps the pll
      `ADCR_RXC_PIN_IN:   in_src = passthrough ? `ADCR_CLK_PLL
                                               : `ADCR_CLK_PIN;
      default:            in_src = `ADCR_CLK_MASTER;
    endcase
    if (converter_disable)
      out_src = in_src;
    else if (out_clk_recovered)
      out_src = (in_src == `ADCR_CLK_PIN) ? `ADCR_CLK_PIN
                                          : `ADCR_CLK_PLL;
    else
      out_src = `ADCR_CLK_MASTER;
  end
  function clk_of;
    input [1:0] src;
    input [3:0] s;
    begin
      case (src)
        `ADCR_CLK_PLL:    clk_of = s[1];
        `ADCR_CLK_PIN:    clk_of = s[3];
        `ADCR_CLK_MASTER: clk_of = s[2];
        default:          clk_of = 1'b0;
      endcase
    end
  endfunction
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      pll_ref_aes            <= 1'b0;
      pll_bypass             <= 1'b0;
      recovered_clock_pin_o  <= 1'b0;
      recovered_clock_pin_oe <= 1'b0;
      in_domain_clk          <= 1'b0;
      out_domain_clk         <= 1'b0;
      in_clk_falling         <= 1'b0;
      out_clk_falling        <= 1'b0;
    end
    else
    begin
      pll_ref_aes <= (receive_clock_select == `ADCR_RXC_PLL_AES);
      pll_bypass  <= (receive_clock_select == `ADCR_RXC_PIN_IN);
      recovered_clock_pin_o  <= passthrough ? pin_s2[2]
                                            : pin_s2[1];
      recovered_clock_pin_oe <= passthrough |
        (receive_clock_select != `ADCR_RXC_PIN_IN);
      in_domain_clk   <= clk_of(in_src, pin_s2);
      out_domain_clk  <= clk_of(out_src, pin_s2);
      in_clk_falling  <= (in_src != `ADCR_CLK_MASTER);
      out_clk_falling <= (out_src != `ADCR_CLK_MASTER);
    end
  end
endmodule // adcr_dataflow_clock_routing
`default_nettype wire

// File: verilog/adcr_regs.vh
// register offsets, field positions, reset values and codes of the router
`ifndef ADCR_REGS_VH
`define ADCR_REGS_VH
// ============================================================
// register byte offsets
`define ADCR_FLOW_CTRL_OFS      8'h00
`define ADCR_CLK_CTRL_OFS       8'h04
`define ADCR_STATUS_OFS         8'h08
// ============================================================
// data-flow control fields
`define ADCR_CONVERTER_DISABLE  0
`define ADCR_SER_OUT_SEL_LO     1
`define ADCR_TX_SRC_SEL_LO      3
`define ADCR_SRC_IN_AES         5
`define ADCR_TRANSMIT_OFF       6
`define ADCR_BYPASS_SWITCH      7
`define ADCR_FLOW_CTRL_RST      8'h0A
// ============================================================
// clock-source control fields
`define ADCR_RX_CLK_SEL_LO      0
`define ADCR_OUT_CLK_RECOVERED  2
`define ADCR_PASSTHROUGH        3
`define ADCR_CLK_CTRL_RST       4'h0
// ============================================================
// status fields
`define ADCR_FLOW_ID_LO         0
`define ADCR_CFG_INVALID        4
`define ADCR_IN_CLK_FALLING     5
`define ADCR_OUT_CLK_FALLING    6
`define ADCR_PLL_MULT_LO        8
`define ADCR_PLL_MULT           9'h100
// ============================================================
// source codes of the output selectors
`define ADCR_SEL_CONVERTER      2'h0
`define ADCR_SEL_SERIAL_IN      2'h1
`define ADCR_SEL_AES_RX         2'h2
`define ADCR_SEL_NONE           2'h3
// receive clock select codes
`define ADCR_RXC_PLL_WORD       2'h0
`define ADCR_RXC_PLL_AES        2'h1
`define ADCR_RXC_PIN_IN         2'h2
`define ADCR_RXC_MASTER         2'h3
// clock domain source codes
`define ADCR_CLK_PLL            2'h0
`define ADCR_CLK_PIN            2'h1
`define ADCR_CLK_MASTER         2'h2
`endif

// File: verilog/adcr_buf2.v
// two-entry stream buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module adcr_buf2 #(
  parameter W     = 24,
  parameter DEPTH = 2,
  parameter AW    = 1
) (
  input  wire         clk_sys,
  input  wire         srst,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0]   count;
  wire push;
  wire pop;
  // ============================================================
  // handshake
  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr];
  // ============================================================
  // storage
  always @(posedge clk_sys)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                   : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                   : rd_ptr + 1'b1;
      if (push & ~pop)
        count <= count + 1'b1;
      else if (pop & ~push)
        count <= count - 1'b1;
    end
  end
endmodule // adcr_buf2
`default_nettype wire

// File: verification/adcr_assertions.sv
// port-level checks of the audio routing block
`timescale 1ns/100ps
`default_nettype none
module adcr_assertions (
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        ser_in_valid,
  input wire logic        ser_in_ready,
  input wire logic        aes_tx_valid,
  input wire logic        receive_pos_input,
  input wire logic        transmit_pos_output,
  input wire logic        transmit_neg_output,
  input wire logic        recovered_clock_pin_oe,
  input wire logic        pll_ref_aes,
  input wire logic        pll_bypass,
  input wire logic [3:0]  flow_id
);
  // ============================================================
  // shadow of the control words, so no internal probe is needed
  logic [7:0] fc;
  logic [3:0] cc;
  wire        wtake = psel && penable && pwrite && pready;
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      fc <= 8'h0A;
      cc <= 4'h0;
    end
    else if (wtake && paddr == 8'h00)
      fc <= pwdata[7:0];
    else if (wtake && paddr == 8'h04)
      cc <= pwdata[3:0];
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // outputs follow a write one edge late, so demand a settled setting
  sequence s_held;
    fc == $past(fc) && cc == $past(cc) && !$past(srst);
  endsequence
  sequence s_bypass;
    (fc[7] && !fc[6])[*4];
  endsequence
  sequence s_take;
    ser_in_valid && ser_in_ready && fc[4:3] == 2'h1;
  endsequence
  AST_TX_OFF: assert property (
    s_held ##0 fc[6] |-> !transmit_pos_output && !transmit_neg_output)
    else $error("transmit outputs not low while off");
  AST_BYP_POS: assert property (
    s_bypass |-> transmit_pos_output == $past(receive_pos_input, 3))
    else $error("bypass positive output wrong");
  AST_BYP_NEG: assert property (
    s_bypass |-> transmit_neg_output == !$past(receive_pos_input, 3))
    else $error("bypass negative output wrong");
  AST_PASS_OE: assert property (
    s_held ##0 cc[3] |-> recovered_clock_pin_oe)
    else $error("passthrough pin not driven");
  AST_PIN_IN: assert property (
    s_held ##0 cc == 4'h2 |-> pll_bypass && !recovered_clock_pin_oe)
    else $error("pin input mode wrong");
  AST_PLL_REF: assert property (
    s_held ##0 !cc[1] |-> pll_ref_aes == cc[0])
    else $error("pll reference wrong");
  AST_FLOW9: assert property (
    s_held ##0 fc == 8'h0A && cc == 4'h0 |-> flow_id == 4'h9)
    else $error("serial to transmitter flow not seen");
  AST_FLOW8: assert property (
    s_held ##0 fc == 8'h1C && cc == 4'h1 |-> flow_id == 4'h8)
    else $error("receive to serial flow not seen");
  AST_TX_FED: assert property (
    s_take |=> aes_tx_valid)
    else $error("serial word lost on way to transmitter");
endmodule // adcr_assertions
bind adcr_dataflow_clock_routing adcr_assertions i_chk (
  .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .ser_in_valid(ser_in_valid), .ser_in_ready(ser_in_ready),
  .aes_tx_valid(aes_tx_valid), .receive_pos_input(receive_pos_input),
  .transmit_pos_output(transmit_pos_output),
  .transmit_neg_output(transmit_neg_output),
  .recovered_clock_pin_oe(recovered_clock_pin_oe),
  .pll_ref_aes(pll_ref_aes), .pll_bypass(pll_bypass), .flow_id(flow_id));
`default_nettype wire

// File: verification/adcr_far_side.sv
// far side: stalling stream sinks and the two audio clocks
`timescale 1ns/100ps
`default_nettype none
module adcr_far_side #(
  parameter int W = 24
) (
  input  wire logic         clk_sys,
  input  wire logic         stall,
  input  wire logic         aes_tx_valid,
  output wire logic         aes_tx_ready,
  input  wire logic [W-1:0] aes_tx_data,
  input  wire logic         ser_out_valid,
  output wire logic         ser_out_ready,
  input  wire logic [W-1:0] ser_out_data,
  output wire logic         src_in_ready,
  output var logic          external_master_clock,
  output var logic          recovered_master_clock
);
  // ============================================================
  logic [W-1:0] got_tx [0:7];
  logic [W-1:0] last_ser;
  int           n_tx = 0;
  // one stall for all sinks, so a word fanned out waits on both
  assign aes_tx_ready = !stall;
  assign ser_out_ready = !stall;
  assign src_in_ready = !stall;
  initial
  begin
    external_master_clock = 1'b0;
    recovered_master_clock = 1'b0;
  end
  // serial input words are sent on clk_sys edges, not in step with these clocks
  always #40 external_master_clock = !external_master_clock;
  // also applied on the pin while the pll is bypassed and passthrough is off
  always #35 recovered_master_clock = !recovered_master_clock;
  always @(posedge clk_sys)
  begin
    if (aes_tx_valid && aes_tx_ready)
    begin
      got_tx[n_tx[2:0]] <= aes_tx_data;
      n_tx <= n_tx + 1;
    end
    if (ser_out_valid && ser_out_ready)
      last_ser <= ser_out_data;
  end
endmodule // adcr_far_side
`default_nettype wire

// File: verification/adcr_dataflow_clock_routing_tb_top.sv
// self-checking bench of the audio routing block
`timescale 1ns/100ps
`default_nettype none
module adcr_dataflow_clock_routing_tb_top;
  localparam int W = 24;
  logic clk_sys = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, e, stall = 1'b0, receive_pos_input = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic aes_rx_valid = 1'b0, ser_in_valid = 1'b0, src_out_valid = 1'b0;
  logic [W-1:0] aes_rx_data = '0, ser_in_data = '0, src_out_data = '0;
  logic [W-1:0] ser_out_data, aes_tx_data, src_in_data;
  logic pready, pslverr, aes_rx_ready, ser_in_ready, src_in_ready;
  logic ser_out_valid, ser_out_ready, aes_tx_valid, aes_tx_ready;
  logic transmit_pos_output, transmit_neg_output, pll_ref_aes, pll_bypass;
  logic recovered_master_clock, external_master_clock, in_domain_clk;
  logic pin_o, pin_oe, in_clk_falling, out_clk_falling;
  logic [3:0] flow_id;
  logic out_domain_clk, src_in_valid, src_out_ready;
  wire pin_w = pin_oe ? pin_o : recovered_master_clock;
  int err_total = 0, check_count = 0;
  logic [11:0] flows [0:8] = '{12'h000, 12'h002, 12'h201, 12'h001,
    12'h007, 12'h281, 12'h0D1, 12'h1C1, 12'h0A0};
  adcr_dataflow_clock_routing #(.W(W)) i_dut (
    .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .aes_rx_valid(aes_rx_valid),
    .aes_rx_ready(aes_rx_ready), .aes_rx_data(aes_rx_data),
    .ser_in_valid(ser_in_valid), .ser_in_ready(ser_in_ready),
    .ser_in_data(ser_in_data), .src_out_valid(src_out_valid),
    .src_out_ready(src_out_ready), .src_out_data(src_out_data),
    .src_in_valid(src_in_valid), .src_in_ready(src_in_ready),
    .src_in_data(src_in_data),
    .ser_out_valid(ser_out_valid), .ser_out_ready(ser_out_ready),
    .ser_out_data(ser_out_data), .aes_tx_valid(aes_tx_valid),
    .aes_tx_ready(aes_tx_ready), .aes_tx_data(aes_tx_data),
    .receive_pos_input(receive_pos_input), .tx_enc_pos(1'b1),
    .tx_enc_neg(1'b0), .transmit_pos_output(transmit_pos_output),
    .transmit_neg_output(transmit_neg_output),
    .recovered_master_clock(recovered_master_clock),
    .external_master_clock(external_master_clock),
    .recovered_clock_pin_i(pin_w), .recovered_clock_pin_o(pin_o),
    .recovered_clock_pin_oe(pin_oe), .pll_ref_aes(pll_ref_aes),
    .pll_bypass(pll_bypass), .in_domain_clk(in_domain_clk),
    .out_domain_clk(out_domain_clk), .in_clk_falling(in_clk_falling),
    .out_clk_falling(out_clk_falling), .flow_id(flow_id));
  adcr_far_side #(.W(W)) i_far (
    .clk_sys(clk_sys), .stall(stall), .aes_tx_valid(aes_tx_valid),
    .aes_tx_ready(aes_tx_ready), .aes_tx_data(aes_tx_data),
    .ser_out_valid(ser_out_valid), .ser_out_ready(ser_out_ready),
    .ser_out_data(ser_out_data), .src_in_ready(src_in_ready),
    .external_master_clock(external_master_clock),
    .recovered_master_clock(recovered_master_clock));
  // ============================================================
  initial
  begin
    forever #2.5 clk_sys = !clk_sys;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    // let the new setting reach the outputs
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic t_regs;
    apb(1'b0, 8'h00, 32'h0);
    chk("flow_rst", q, 32'h0A);
    apb(1'b0, 8'h04, 32'h0);
    chk("clk_rst", q, 32'h0);
    wr(8'h08, 32'hFFFF_FFFF);
    wr(8'h10, 32'h0000_00FF);
    chk("bad_err", e, 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    chk("status", q & 32'h0001_FF1F, 32'h0001_0009);
    apb(1'b0, 8'h00, 32'h0);
    chk("flow_kept", q, 32'h0A);
  endtask
  task automatic t_flows;
    logic [3:0] c;
    logic fi;
    for (int i = 0; i < 9; i++)
    begin
      c = flows[i][3:0];
      fi = (c[1:0] != 2'h3);
      wr(8'h00, {24'h0, flows[i][11:4]});
      wr(8'h04, {28'h0, c});
      apb(1'b0, 8'h08, 32'h0);
      chk("flow_id", q[4:0], 32'(i + 1));
      chk("in_fall", in_clk_falling, fi);
      chk("out_fall", out_clk_falling, flows[i][4] ? fi : c[2]);
      if (!c[1])
        chk("pll_ref", pll_ref_aes, c[0]);
    end
  endtask
  task automatic t_pins;
    wr(8'h04, 32'h08);
    @(posedge external_master_clock);
    repeat (4) @(posedge clk_sys);
    chk("pass", {pin_oe, pin_w, out_domain_clk}, 3'h7);
    wr(8'h04, 32'h02);
    chk("pin_mode", {pll_bypass, pin_oe}, 2'h2);
    @(posedge recovered_master_clock);
    repeat (4) @(posedge clk_sys);
    chk("pin_clk", in_domain_clk, 1'b1);
    wr(8'h04, 32'h0A);
    chk("pass_oe", pin_oe, 1'b1);
    wr(8'h04, 32'h00);
  endtask
  task automatic t_tx;
    logic [7:0] b;
    for (int k = 0; k < 2; k++)
    begin
      b = k ? 8'h20 : 8'h0A;
      wr(8'h00, {24'h0, b | 8'h80});
      for (int v = 0; v < 2; v++)
      begin
        receive_pos_input <= v[0];
        repeat (4) @(posedge clk_sys);
        chk("byp", {transmit_pos_output, transmit_neg_output},
            {v[0], !v[0]});
      end
      wr(8'h00, {24'h0, b | 8'hC0});
      chk("off", {transmit_pos_output, transmit_neg_output}, 2'h0);
      receive_pos_input <= 1'b0;
    end
    wr(8'h00, 32'h0A);
  endtask
  task automatic t_stream;
    stall <= 1'b1;
    ser_in_valid <= 1'b1;
    for (int i = 1; i <= 3; i++)
    begin
      ser_in_data <= 24'hC0_0000 | 24'(i);
      if (i == 3)
      begin
        repeat (3) @(posedge clk_sys);
        chk("full", ser_in_ready, 1'b0);
        stall <= 1'b0;
      end
      do @(posedge clk_sys); while (ser_in_ready !== 1'b1);
    end
    ser_in_valid <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk("n_tx", i_far.n_tx, 3);
    for (int i = 0; i < 3; i++)
      chk("tx_word", i_far.got_tx[i], 24'hC0_0001 + i);
    chk("ser_word", i_far.last_ser, 24'hC0_0003);
    wr(8'h00, 32'h00);
    ser_in_valid <= 1'b1;
    do @(posedge clk_sys); while (ser_in_ready !== 1'b1);
    ser_in_valid <= 1'b0;
    @(posedge clk_sys);
    chk("conv_in", {src_in_valid, src_out_ready, src_in_data},
        {2'h3, 24'hC0_0003});
    wr(8'h00, 32'h1C);
    wr(8'h04, 32'h01);
    aes_rx_valid <= 1'b1;
    aes_rx_data <= 24'h5A_5A5A;
    do @(posedge clk_sys); while (aes_rx_ready !== 1'b1);
    aes_rx_valid <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("rx_word", i_far.last_ser, 24'h5A_5A5A);
    chk("idle", {ser_in_ready, aes_tx_valid}, 2'h0);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // a hang ends the run through the same closing task
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    conclude;
  end
  initial
  begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    t_regs;
    t_flows;
    t_pins;
    t_tx;
    t_stream;
    conclude;
  end
endmodule // adcr_dataflow_clock_routing_tb_top
`default_nettype wire
